// ---- include/npic_cfg.svh ----
/*
  offsets, field positions, reset values and codes of the nested
  priority interrupt controller.
  assumes: included by the package and the controller; macros only.
*/
`ifndef NPIC_CFG_SVH
`define NPIC_CFG_SVH

`define NPIC_NVEC       14
`define NPIC_OFS_SPR0   8'h00
`define NPIC_OFS_SPR1   8'h04
`define NPIC_OFS_SPR2   8'h08
`define NPIC_OFS_SPR3   8'h0c
`define NPIC_OFS_CC     8'h10
`define NPIC_OFS_EN     8'h14
`define NPIC_OFS_EXT    8'h18
`define NPIC_OFS_STAT   8'h1c
`define NPIC_SPR_RST    32'hffffffff
`define NPIC_SPR3_RO    8'hf0
`define NPIC_CC_RST     8'hea
`define NPIC_CC_I1      5
`define NPIC_CC_I0      3
`define NPIC_LVL0       2'b10
`define NPIC_LVL3       2'b11
`define NPIC_NMI_LVL    3'd4
`define NPIC_VEC_RESET  16'hfffe
`define NPIC_VEC_TRAP   16'hfffc
`define NPIC_VEC_TOP    16'hfffa
`define NPIC_LAST_PUSH  2'd3
`define NPIC_SENS_FALL  2'd0
`define NPIC_SENS_RISE  2'd1
`define NPIC_SENS_BOTH  2'd2
`define NPIC_SENS_LEVEL 2'd3
`define NPIC_RESP_OK    2'b00
`define NPIC_RESP_ERR   2'b10

`endif

// ---- include/npic_pkg.sv ----
/*
  types of the nested priority interrupt controller: sequencer and
  power-mode states, and the packed state record.
  assumes: npic_cfg.svh on the include path.
*/
package npic_pkg;
  `include "npic_cfg.svh"

  typedef enum logic [1:0] {S_IDLE, S_STACK, S_VEC, S_FETCH} npic_fsm_t;
  typedef enum logic [1:0] {M_RUN, M_WAIT, M_HALT} npic_pm_t;

  typedef struct packed {
    logic [31:0]            spr;
    logic [7:0]             cc;
    logic [`NPIC_NVEC-1:0]  src_en;
    logic [1:0]             sens;
    logic [3:0]             pin_sel;
    logic [`NPIC_NVEC-1:0]  pend;
    logic [`NPIC_NVEC-1:0]  line_prev;
    logic                   tli_prev;
    logic                   trap_p;
    npic_fsm_t              fsm;
    npic_pm_t               pm;
    logic [1:0]             cnt;
    logic [15:0]            vec;
    logic [1:0]             nl;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } npic_st_t;
endpackage : npic_pkg

// ---- logic/npic_ctrl.sv ----
/*
  nested priority interrupt controller with an AXI4-Lite register slave.
  assumes: core gives one-cycle instruction strobes on MCLK; peripherals
  hold their flags as levels; all inputs synchronous to MCLK.
*/
`include "npic_cfg.svh"

// Overview of operation
// - priority level in cc bits 5 and 3
// - four levels, sixteen vectors at FFE0h..FFFFh
// - service at instruction boundary, or on wake from wait or halt
// - push pc, x, a, cc on entry
// - maskable entry loads stored vector priority
// - load vector then fetch first instruction
// - interrupt return restores saved priority bits
// - highest software level wins, hardware order ties
// - unserviced requests stay latched until highest
// - reset, pin interrupt, trap ignore priority bits
// - non-maskable: stack except reset, level 3
// - pin interrupt on designated pin edge
// - trap behaves like pin interrupt, preemptible
// - reset first, routine runs at level 3
// - maskable needs enable and higher stored level
// - external edge latched, cleared on entry
// - selected pins of a line are nanded
// - peripheral request is flag and enable
// - clear sequence drops the pending latch
// - halt exit only by halt-capable sources
// - non-halt source served right after that
// - instructions may also change priority bits
// - level 0 writes to a field ignored
// - priority registers reset to all ones
module npic_ctrl #(
  parameter logic [`NPIC_NVEC-1:0] HALT_MASK = 14'h0667,
  parameter logic [`NPIC_NVEC-1:0] EXT_MASK  = 14'h0244,
  parameter bit                    TLI_RISE  = 1'b0
) (
  input  wire logic                    MCLK,
  input  wire logic                    RST,
  input  wire logic [7:0]              S_AXI_AWADDR,
  input  wire logic                    S_AXI_AWVALID,
  output wire logic                    S_AXI_AWREADY,
  input  wire logic [31:0]             S_AXI_WDATA,
  input  wire logic [3:0]              S_AXI_WSTRB,
  input  wire logic                    S_AXI_WVALID,
  output wire logic                    S_AXI_WREADY,
  output wire logic [1:0]              S_AXI_BRESP,
  output wire logic                    S_AXI_BVALID,
  input  wire logic                    S_AXI_BREADY,
  input  wire logic [7:0]              S_AXI_ARADDR,
  input  wire logic                    S_AXI_ARVALID,
  output wire logic                    S_AXI_ARREADY,
  output wire logic [31:0]             S_AXI_RDATA,
  output wire logic [1:0]              S_AXI_RRESP,
  output wire logic                    S_AXI_RVALID,
  input  wire logic                    S_AXI_RREADY,
  input  wire logic                    INSTR_END,
  input  wire logic                    TRAP_EXEC,
  input  wire logic                    INTERRUPT_RETURN_INSTRUCTION_EXEC,
  input  wire logic                    CC_POP,
  input  wire logic [7:0]              CC_IN,
  input  wire logic                    RIM_EXEC,
  input  wire logic                    SIM_EXEC,
  input  wire logic                    WFI_EXEC,
  input  wire logic                    HALT_EXEC,
  input  wire logic                    TLI_PIN,
  input  wire logic [4*`NPIC_NVEC-1:0] EXT_PINS,
  input  wire logic [`NPIC_NVEC-1:0]   SRC_FLAG,
  input  wire logic [`NPIC_NVEC-1:0]   SRC_CLR,
  output wire logic                    PUSH_STB,
  output wire logic [1:0]              PUSH_SEL,
  output wire logic                    VEC_LOAD,
  output wire logic [15:0]             VEC_ADDR,
  output wire logic                    FETCH_STB,
  output wire logic [7:0]              CC_OUT,
  output wire logic                    WAIT_MODE,
  output wire logic                    HALT_MODE,
  output wire logic                    BUSY
);
  import npic_pkg::*;

  localparam int NV = `NPIC_NVEC;

  npic_st_t s_r;
  npic_st_t s_nxt;

  logic [NV-1:0] line;
  logic [NV-1:0] ev;
  logic [NV-1:0] set_req;
  logic [NV-1:0] elig;
  logic [2:0]    swl [NV];
  logic [1:0]    cur_lvl;
  logic          aw_go;
  logic          ar_go;
  logic          tli_now;
  logic          tli_edge;
  logic          trap_any;

  // encoded bits to numeric level: 10->0, 01->1, 00->2, 11->3
  function automatic logic [1:0] lvl_of(input logic [1:0] b);
    lvl_of = {~(b[1] ^ b[0]), b[0]};
  endfunction : lvl_of

  assign cur_lvl  = lvl_of({s_r.cc[`NPIC_CC_I1], s_r.cc[`NPIC_CC_I0]});
  assign tli_now  = TLI_RISE ? TLI_PIN : ~TLI_PIN;
  assign tli_edge = tli_now & ~s_r.tli_prev;
  assign trap_any = s_r.trap_p | TRAP_EXEC;

  genvar gi;
  generate
    for (gi = 0; gi < NV; gi++) begin : g_src
      if (EXT_MASK[gi]) begin : g_ext
        // unselected pins count as high so they do not force the line
        assign line[gi] = ~&(EXT_PINS[4*gi +: 4] | ~s_r.pin_sel);
        // one driver per bit; level mode requests while the line is low
        assign ev[gi] = (s_r.sens == `NPIC_SENS_FALL) ? ~line[gi] & s_r.line_prev[gi]
                      : (s_r.sens == `NPIC_SENS_RISE) ? line[gi] & ~s_r.line_prev[gi]
                      : (s_r.sens == `NPIC_SENS_BOTH) ? line[gi] ^ s_r.line_prev[gi]
                      : ~line[gi];
        assign set_req[gi] = ev[gi];
      end else begin : g_per
        assign line[gi]    = 1'b0;
        assign ev[gi]      = 1'b0;
        assign set_req[gi] = SRC_FLAG[gi] & s_r.src_en[gi];
      end
      if (gi == 0) begin : g_tli
        // the pin interrupt outranks every software level
        assign swl[gi]  = `NPIC_NMI_LVL;
        assign elig[gi] = s_r.pend[gi];
      end else begin : g_msk
        assign swl[gi]  = {1'b0, lvl_of(s_r.spr[2*gi +: 2])};
        assign elig[gi] = s_r.pend[gi] & s_r.src_en[gi]
                        & (swl[gi][1:0] > cur_lvl)
                        & (cur_lvl != 2'd3);
      end
    end
  endgenerate

  assign aw_go = S_AXI_AWVALID & S_AXI_WVALID & ~s_r.bvalid;
  assign ar_go = S_AXI_ARVALID & ~s_r.rvalid;

  always_comb begin
    logic [NV-1:0] cand;
    logic [NV-1:0] clr;
    logic [2:0]    best_l;
    logic [3:0]    best;
    logic          found;
    logic          boundary;
    logic          wake;
    logic [31:0]   rd;
    logic          rok;
    logic [1:0]    fld;
    cand     = '0;
    clr      = '0;
    best_l   = '0;
    best     = '0;
    found    = 1'b0;
    boundary = 1'b0;
    wake     = 1'b0;
    rd       = '0;
    rok      = 1'b1;
    fld      = '0;
    s_nxt    = s_r;

    // register writes
    if (s_r.bvalid && S_AXI_BREADY) begin
      s_nxt.bvalid = 1'b0;
    end
    if (aw_go) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = `NPIC_RESP_OK;
      case (S_AXI_AWADDR)
        `NPIC_OFS_SPR0, `NPIC_OFS_SPR1, `NPIC_OFS_SPR2, `NPIC_OFS_SPR3: begin
          if (S_AXI_WSTRB[0]) begin
            for (int f = 0; f < 4; f++) begin
              fld = S_AXI_WDATA[2*f +: 2];
              // a level 0 code keeps the old field; top nibble of reg 3 fixed
              if (fld != `NPIC_LVL0
                  && !(S_AXI_AWADDR == `NPIC_OFS_SPR3 && f > 1)) begin
                s_nxt.spr[8*S_AXI_AWADDR[3:2] + 2*f +: 2] = fld;
              end
            end
          end
        end
        `NPIC_OFS_CC: begin
          if (S_AXI_WSTRB[0]) begin
            s_nxt.cc = S_AXI_WDATA[7:0];
          end
        end
        `NPIC_OFS_EN: begin
          if (S_AXI_WSTRB[0]) begin
            s_nxt.src_en[7:0] = S_AXI_WDATA[7:0];
          end
          if (S_AXI_WSTRB[1]) begin
            s_nxt.src_en[NV-1:8] = S_AXI_WDATA[NV-1:8];
          end
        end
        `NPIC_OFS_EXT: begin
          if (S_AXI_WSTRB[0]) begin
            s_nxt.sens    = S_AXI_WDATA[1:0];
            s_nxt.pin_sel = S_AXI_WDATA[7:4];
          end
        end
        `NPIC_OFS_STAT: begin
          s_nxt.bresp = `NPIC_RESP_OK;
        end
        default: begin
          s_nxt.bresp = `NPIC_RESP_ERR;
        end
      endcase
    end

    // register reads
    case (S_AXI_ARADDR)
      `NPIC_OFS_SPR0: rd = {24'h0, s_r.spr[7:0]};
      `NPIC_OFS_SPR1: rd = {24'h0, s_r.spr[15:8]};
      `NPIC_OFS_SPR2: rd = {24'h0, s_r.spr[23:16]};
      `NPIC_OFS_SPR3: rd = {24'h0, s_r.spr[31:24] | `NPIC_SPR3_RO};
      `NPIC_OFS_CC:   rd = {24'h0, s_r.cc};
      `NPIC_OFS_EN:   rd = {18'h0, s_r.src_en};
      `NPIC_OFS_EXT:  rd = {24'h0, s_r.pin_sel, 2'b00, s_r.sens};
      `NPIC_OFS_STAT: rd = {13'h0, s_r.pm, s_r.fsm, s_r.trap_p, s_r.pend};
      default:        rok = 1'b0;
    endcase
    if (s_r.rvalid && S_AXI_RREADY) begin
      s_nxt.rvalid = 1'b0;
    end
    if (ar_go) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rok ? rd : 32'h0;
      s_nxt.rresp  = rok ? `NPIC_RESP_OK : `NPIC_RESP_ERR;
    end

    // arbitration; in halt only halt-capable sources compete
    cand = (s_r.pm == M_HALT) ? (elig & HALT_MASK) : elig;
    // walk low to high hardware priority, >= lets the higher one win ties
    for (int i = NV - 1; i >= 0; i--) begin
      if (cand[i] && (!found || swl[i] >= best_l)) begin
        found  = 1'b1;
        best_l = swl[i];
        best   = 4'(i);
      end
    end

    // priority changes made by the running code
    if (s_r.fsm == S_IDLE) begin
      if (INTERRUPT_RETURN_INSTRUCTION_EXEC || CC_POP) begin
        s_nxt.cc = CC_IN;
      end
      if (RIM_EXEC || WFI_EXEC || HALT_EXEC) begin
        s_nxt.cc[`NPIC_CC_I1] = 1'b1;
        s_nxt.cc[`NPIC_CC_I0] = 1'b0;
      end
      if (SIM_EXEC) begin
        s_nxt.cc[`NPIC_CC_I1] = 1'b1;
        s_nxt.cc[`NPIC_CC_I0] = 1'b1;
      end
      if (WFI_EXEC) begin
        s_nxt.pm = M_WAIT;
      end
      if (HALT_EXEC) begin
        s_nxt.pm = M_HALT;
      end
    end

    s_nxt.trap_p = trap_any;
    boundary = INSTR_END && s_r.fsm == S_IDLE && s_r.pm == M_RUN;
    // any serviceable source ends wait, only halt-capable ones end halt
    wake = s_r.pm != M_RUN && s_r.fsm == S_IDLE && found;

    // sequencer
    case (s_r.fsm)
      S_IDLE: begin
        if (boundary && trap_any) begin
          s_nxt.fsm    = S_STACK;
          s_nxt.cnt    = '0;
          s_nxt.vec    = `NPIC_VEC_TRAP;
          s_nxt.nl     = `NPIC_LVL3;
          s_nxt.trap_p = 1'b0;
        end else if ((boundary && found) || wake) begin
          s_nxt.fsm = S_STACK;
          s_nxt.cnt = '0;
          s_nxt.pm  = M_RUN;
          s_nxt.vec = `NPIC_VEC_TOP - {11'h0, best, 1'b0};
          if (best == 4'd0) begin
            s_nxt.nl = `NPIC_LVL3;
          end else begin
            s_nxt.nl = s_r.spr[2*best +: 2];
          end
          if (EXT_MASK[best] && s_r.sens != `NPIC_SENS_LEVEL) begin
            clr[best] = 1'b1;
          end
          if (best == 4'd0) begin
            clr[0] = 1'b1;
          end
        end
      end
      S_STACK: begin
        // pc, x, a, cc in that order; cc goes out before it is reloaded
        s_nxt.cnt = s_r.cnt + 2'd1;
        if (s_r.cnt == `NPIC_LAST_PUSH) begin
          s_nxt.fsm = S_VEC;
        end
      end
      S_VEC: begin
        s_nxt.cc[`NPIC_CC_I1] = s_r.nl[1];
        s_nxt.cc[`NPIC_CC_I0] = s_r.nl[0];
        s_nxt.fsm = S_FETCH;
      end
      S_FETCH: begin
        s_nxt.fsm = S_IDLE;
      end
      default: begin
        s_nxt.fsm = S_IDLE;
      end
    endcase

    // pending latches; a fresh request beats a clear in the same cycle
    for (int i = 1; i < NV; i++) begin
      if (!EXT_MASK[i]) begin
        clr[i] = SRC_CLR[i];
      end else if (s_r.sens == `NPIC_SENS_LEVEL) begin
        clr[i] = 1'b1;
      end
    end
    s_nxt.pend    = set_req | (s_r.pend & ~clr);
    s_nxt.pend[0] = tli_edge | (s_r.pend[0] & ~clr[0]);
    s_nxt.line_prev = line;
    s_nxt.tli_prev  = tli_now;
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      s_r           <= '0;
      s_r.spr       <= `NPIC_SPR_RST;
      s_r.cc        <= `NPIC_CC_RST;
      s_r.fsm       <= S_VEC;
      s_r.pm        <= M_RUN;
      s_r.vec       <= `NPIC_VEC_RESET;
      s_r.nl        <= `NPIC_LVL3;
      s_r.line_prev <= '0;
      s_r.tli_prev  <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign S_AXI_AWREADY = aw_go;
  assign S_AXI_WREADY  = aw_go;
  assign S_AXI_BVALID  = s_r.bvalid;
  assign S_AXI_BRESP   = s_r.bresp;
  assign S_AXI_ARREADY = ~s_r.rvalid;
  assign S_AXI_RVALID  = s_r.rvalid;
  assign S_AXI_RDATA   = s_r.rdata;
  assign S_AXI_RRESP   = s_r.rresp;
  assign PUSH_STB      = s_r.fsm == S_STACK;
  assign PUSH_SEL      = s_r.cnt;
  assign VEC_LOAD      = s_r.fsm == S_VEC;
  assign VEC_ADDR      = s_r.vec;
  assign FETCH_STB     = s_r.fsm == S_FETCH;
  assign CC_OUT        = s_r.cc;
  assign WAIT_MODE     = s_r.pm == M_WAIT;
  assign HALT_MODE     = s_r.pm == M_HALT;
  assign BUSY          = s_r.fsm != S_IDLE;
endmodule : npic_ctrl

// ---- tb/npic_chk_sva.sv ----
/* port checker of the interrupt controller.
   assumes: bound into npic_ctrl, one clock MCLK, RST async active high. */
module npic_chk_sva (
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        INSTR_END,
  input wire logic        INTERRUPT_RETURN_INSTRUCTION_EXEC,
  input wire logic [7:0]  CC_IN,
  input wire logic        RIM_EXEC,
  input wire logic        SIM_EXEC,
  input wire logic        WFI_EXEC,
  input wire logic        HALT_EXEC,
  input wire logic        PUSH_STB,
  input wire logic [1:0]  PUSH_SEL,
  input wire logic        VEC_LOAD,
  input wire logic [15:0] VEC_ADDR,
  input wire logic        FETCH_STB,
  input wire logic [7:0]  CC_OUT,
  input wire logic        WAIT_MODE,
  input wire logic        HALT_MODE,
  input wire logic        BUSY
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence stack_s;
    PUSH_SEL == 2'd0 ##1 PUSH_SEL == 2'd1 ##1 PUSH_SEL == 2'd2 ##1 PUSH_SEL == 2'd3;
  endsequence
  sequence load_s;
    VEC_LOAD && !PUSH_STB ##1 FETCH_STB ##1 !BUSY;
  endsequence
  chk_stack_order: assert property ($rose(PUSH_STB) |-> stack_s ##1 load_s)
    else $error("entry steps out of order");
  chk_push_len: assert property ($rose(PUSH_STB) |-> PUSH_STB [*4] ##1 !PUSH_STB)
    else $error("stacking is not four pushes");
  chk_entry_edge: assert property ($rose(PUSH_STB) |->
    $past(INSTR_END) || $past(WAIT_MODE) || $past(HALT_MODE))
    else $error("entry off an instruction boundary");
  chk_nmi_level: assert property (VEC_LOAD && VEC_ADDR >= 16'hfffa |=>
    CC_OUT[5] && CC_OUT[3])
    else $error("non-maskable entry not at level 3");
  chk_vec_top: assert property (VEC_LOAD |-> VEC_ADDR >= 16'hffe0 && !VEC_ADDR[0])
    else $error("vector outside the top area");
  chk_ret_level: assert property (INTERRUPT_RETURN_INSTRUCTION_EXEC && !BUSY |=>
    CC_OUT[5] == $past(CC_IN[5]) && CC_OUT[3] == $past(CC_IN[3]))
    else $error("return did not restore level");
  chk_main_level: assert property ((RIM_EXEC || WFI_EXEC || HALT_EXEC) && !BUSY |=>
    CC_OUT[5] && !CC_OUT[3])
    else $error("level 0 not set by instruction");
  chk_mask_level: assert property (SIM_EXEC && !BUSY |=> CC_OUT[5] && CC_OUT[3])
    else $error("level 3 not set by instruction");
  chk_wr_resp: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> S_AXI_BVALID)
    else $error("write answer late");
endmodule : npic_chk_sva

bind npic_ctrl npic_chk_sva u_chk (.MCLK, .RST, .S_AXI_AWVALID, .S_AXI_AWREADY,
  .S_AXI_BVALID, .INSTR_END, .INTERRUPT_RETURN_INSTRUCTION_EXEC, .CC_IN, .RIM_EXEC, .SIM_EXEC, .WFI_EXEC,
  .HALT_EXEC, .PUSH_STB, .PUSH_SEL, .VEC_LOAD, .VEC_ADDR, .FETCH_STB, .CC_OUT,
  .WAIT_MODE, .HALT_MODE, .BUSY);

// ---- tb/npic_core_mdl.sv ----
/* core model: instruction boundaries while the controller is idle.
   assumes: clock and reset of the controller. */
module npic_core_mdl (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic busy,
  input  wire logic slow,
  output wire logic instr_end
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] gap_r;
  logic       end_r;
  assign instr_end = end_r;
  // gaps between boundaries leave the bench room to act
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_r <= 2'd0;
      end_r <= 1'b0;
    end else begin
      gap_r <= gap_r + 2'd1;
      end_r <= !busy && (gap_r == 2'd3 || (!slow && gap_r == 2'd1));
    end
  end
endmodule : npic_core_mdl

// ---- tb/tb.sv ----
/* bench: AXI4-Lite master, core model, peripheral flags, arbitration model.
   assumes: npic_ctrl, npic_core_mdl and npic_chk_sva compiled before. */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [13:0] HMASK = 14'h0667;
  logic        MCLK, RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID;
  logic        S_AXI_RREADY, TRAP_EXEC, INTERRUPT_RETURN_INSTRUCTION_EXEC, CC_POP, RIM_EXEC, SIM_EXEC;
  logic        WFI_EXEC, HALT_EXEC, TLI_PIN, slow;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, CC_IN;
  logic [31:0] S_AXI_WDATA, rdv;
  logic [3:0]  S_AXI_WSTRB;
  logic [55:0] EXT_PINS;
  logic [13:0] SRC_FLAG, SRC_CLR, en, fl;
  logic [1:0]  rsp;
  logic [15:0] a;
  logic [31:0] spr_m [4] = '{4{32'hff}};
  bit          f;
  int          cur = 0, seed = 32'h3ffc, err_count = 0, cmp_count = 0;
  wire         S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  wire         INSTR_END, PUSH_STB, VEC_LOAD, FETCH_STB, WAIT_MODE, HALT_MODE, BUSY;
  wire [1:0]   S_AXI_BRESP, S_AXI_RRESP, PUSH_SEL;
  wire [31:0]  S_AXI_RDATA;
  wire [15:0]  VEC_ADDR;
  wire [7:0]   CC_OUT;
  npic_ctrl #(.HALT_MASK(HMASK)) DUT (.MCLK, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
    .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
    .INSTR_END, .TRAP_EXEC, .INTERRUPT_RETURN_INSTRUCTION_EXEC, .CC_POP, .CC_IN, .RIM_EXEC, .SIM_EXEC,
    .WFI_EXEC, .HALT_EXEC, .TLI_PIN, .EXT_PINS, .SRC_FLAG, .SRC_CLR, .PUSH_STB,
    .PUSH_SEL, .VEC_LOAD, .VEC_ADDR, .FETCH_STB, .CC_OUT, .WAIT_MODE, .HALT_MODE, .BUSY);
  npic_core_mdl u_core (.clk(MCLK), .rst(RST), .busy(BUSY), .slow(slow),
    .instr_end(INSTR_END));
  function automatic logic [1:0] fld(int i);
    return spr_m[i / 4][2 * (i % 4) +: 2];
  endfunction : fld
  function automatic int lvl(logic [1:0] b);
    return b == 2'b10 ? 0 : b == 2'b01 ? 1 : b == 2'b00 ? 2 : 3;
  endfunction : lvl
  // highest level first, lowest index breaks ties
  function automatic int win(logic [13:0] req, bit hl);
    int w = -1;
    for (int i = 1; i < 14; i++)
      if (req[i] && lvl(fld(i)) > cur && (!hl || HMASK[i]) && (w < 0 || lvl(fld(i)) > lvl(fld(w))))
        w = i;
    return w;
  endfunction : win
  task automatic chk(logic [35:0] seen, logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(logic [7:0] ad, logic [31:0] d, output logic [1:0] r);
    @(posedge MCLK);
    S_AXI_AWADDR <= ad;
    S_AXI_WDATA <= d;
    {S_AXI_AWVALID, S_AXI_WVALID} <= 2'b11;
    do @(negedge MCLK); while (S_AXI_AWREADY !== 1'b1 || S_AXI_WREADY !== 1'b1);
    @(posedge MCLK);
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'b001;
    do @(negedge MCLK); while (S_AXI_BVALID !== 1'b1);
    r = S_AXI_BRESP;
    @(posedge MCLK);
    S_AXI_BREADY <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
    @(posedge MCLK);
    S_AXI_ARADDR <= ad;
    S_AXI_ARVALID <= 1'b1;
    do @(negedge MCLK); while (S_AXI_ARREADY !== 1'b1);
    @(posedge MCLK);
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'b01;
    do @(negedge MCLK); while (S_AXI_RVALID !== 1'b1);
    {r, d} = {S_AXI_RRESP, S_AXI_RDATA};
    @(posedge MCLK);
    S_AXI_RREADY <= 1'b0;
  endtask : rd
  // k: 0 trap, 1 return, 2 level 0, 3 level 3, 4 wait, 5 halt, 6 pop
  task automatic strobe(int k);
    do @(negedge MCLK); while (BUSY !== 1'b0);
    @(posedge MCLK);
    {TRAP_EXEC, INTERRUPT_RETURN_INSTRUCTION_EXEC, RIM_EXEC, SIM_EXEC, WFI_EXEC, HALT_EXEC, CC_POP} <= 7'h40 >> k;
    @(posedge MCLK);
    {TRAP_EXEC, INTERRUPT_RETURN_INSTRUCTION_EXEC, RIM_EXEC, SIM_EXEC, WFI_EXEC, HALT_EXEC, CC_POP} <= 7'h0;
  endtask : strobe
  task automatic entry(output bit fd, output logic [15:0] ad);
    fd = 0;
    for (int k = 0; k < 40 && !fd; k++) begin
      @(negedge MCLK);
      fd = VEC_LOAD === 1'b1;
    end
    ad = VEC_ADDR;
    @(negedge MCLK);
  endtask : entry
  task automatic serve(logic [13:0] req, bit hl);
    int w = win(req, hl);
    while (w > 0) begin
      entry(f, a);
      chk(f, 1);
      chk(a, 16'hfffa - 16'(2 * w));
      chk({CC_OUT[5], CC_OUT[3]}, fld(w));
      cur = lvl(fld(w));
      req[w] = 1'b0;
      @(posedge MCLK);
      SRC_FLAG[w] <= 1'b0;
      SRC_CLR[w] <= 1'b1;
      @(posedge MCLK);
      SRC_CLR <= '0;
      w = win(req, 1'b0);
      if (w < 0 && req != 0) begin
        strobe(1);
        cur = 0;
        w = win(req, 1'b0);
      end
    end
    entry(f, a);
    chk(f, 0);
    strobe(1);
    cur = 0;
  endtask : serve
  task automatic end_sim();
    $display("mismatches %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  initial begin
    repeat (60000) @(posedge MCLK);
    err_count++;
    end_sim();
  end
  initial begin
    {RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 6'h20;
    {TRAP_EXEC, INTERRUPT_RETURN_INSTRUCTION_EXEC, RIM_EXEC, SIM_EXEC, WFI_EXEC, HALT_EXEC, CC_POP} = 7'h0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, SRC_FLAG, SRC_CLR} = '0;
    {TLI_PIN, slow, S_AXI_WSTRB, CC_IN, EXT_PINS} = {2'b10, 4'hf, 8'he2, 56'hffffffffffffff};
    repeat (12) @(posedge MCLK);
    RST <= 1'b0;
    do @(negedge MCLK); while (BUSY !== 1'b0);
    chk(VEC_ADDR, 16'hfffe);
    chk({CC_OUT[5], CC_OUT[3]}, 2'b11);
    for (int i = 0; i < 4; i++) begin
      rd(8'(4 * i), rdv, rsp);
      chk(rdv[7:0], 8'hff);
    end
    rd(8'h20, rdv, rsp);
    chk({rsp, rdv}, {2'b10, 32'h0});
    wr(8'h20, 32'h0, rsp);
    chk(rsp, 2'b10);
    for (int r = 0; r < 9; r++) begin
      for (int i = 0; i < 4; i++) begin
        rdv = 32'($random(seed)) & 32'hff;
        wr(8'(4 * i), rdv, rsp);
        for (int k = 0; k < 4; k++)
          if (rdv[2 * k +: 2] != 2'b10 && !(i == 3 && k > 1))
            spr_m[i][2 * k +: 2] = rdv[2 * k +: 2];
        rd(8'(4 * i), rdv, rsp);
        chk(rdv[7:0], spr_m[i][7:0]);
      end
      en = 14'($random(seed)) | 14'h0002;
      fl = 14'($random(seed)) & 14'h3dba | 14'h0002;
      wr(8'h14, 32'(en), rsp);
      slow <= r[0];
      strobe(2);
      if (r % 3 != 0) begin
        strobe(r % 3 + 3);
        @(negedge MCLK);
        chk(r % 3 == 1 ? WAIT_MODE : HALT_MODE, 1);
      end
      @(posedge MCLK);
      SRC_FLAG <= fl;
      serve(fl & en, r % 3 == 2);
      @(posedge MCLK);
      {SRC_FLAG, SRC_CLR} <= {14'h0, 14'h3fff};
      @(posedge MCLK);
      SRC_CLR <= '0;
    end
    CC_IN <= 8'($random(seed));
    strobe(6);
    rd(8'h10, rdv, rsp);
    chk(rdv[7:0], CC_IN);
    CC_IN <= 8'he2;
    // external line 2: pins 0 and 1 selected, line rise requests
    wr(8'h14, 32'h4, rsp);
    wr(8'h18, 32'h31, rsp);
    rd(8'h18, rdv, rsp);
    chk(rdv, 32'h31);
    strobe(2);
    @(posedge MCLK);
    EXT_PINS[8] <= 1'b0;
    entry(f, a);
    chk({f, a}, {1'b1, 16'hfff6});
    chk({CC_OUT[5], CC_OUT[3]}, fld(2));
    rd(8'h1c, rdv, rsp);
    chk(rdv, 32'h0);
    strobe(1);
    EXT_PINS[8] <= 1'b1;
    strobe(3);
    TLI_PIN <= 1'b0;
    entry(f, a);
    chk({f, a}, {1'b1, 16'hfffa});
    chk({CC_OUT[5], CC_OUT[3]}, 2'b11);
    strobe(1);
    TLI_PIN <= 1'b1;
    strobe(0); // trap only outside the pin routine
    entry(f, a);
    chk({f, a}, {1'b1, 16'hfffc});
    chk({CC_OUT[5], CC_OUT[3]}, 2'b11);
    end_sim();
  end
endmodule : tb
